// ==== rtl/bus_xfer_ctrl.sv ====
/*
  processor-side control of a multiplexed address/data bus: address strobe,
  data drive permit, burst / same-page flag, read and write strobes, diag pin.
  assumes the core holds its request until done pulses; ack and the capture
  enable come from outside and are synchronised here.
*/
// Functional notes
// - diag high in address phase of a read when it is a cache miss.
// - diag high in data phase of a read for instruction fetches.
// - address strobe pulses while the bus carries a valid address.
// - drive permit on reads only after the device stops driving the bus.
// - burst flag on a read requests four contiguous words.
// - burst only on misses: all instruction misses, data misses if configured.
// - on writes, flag marks back-to-back writes in the same 256 byte page.
// - read strobe marks a read transaction.
// - write strobe marks a write transaction.
// - write ack advances to the next item or ends the cycle.
// - read ack lets the core use the returned data.
// - each transaction has an address phase then a data phase.
`timescale 1ns/1ps
`default_nettype none
module bus_xfer_ctrl
  import bus_xfer_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire logic                      req,
  input  wire logic                      req_write,
  input  wire logic                      req_miss,
  input  wire logic                      req_instr,
  input  wire logic [1:0]                req_items,
  input  wire logic [bus_xfer_pkg::ADDR_W-1:0] req_addr,
  input  wire logic                      dblock_refill_en,
  input  wire logic                      ack_pin,
  input  wire logic                      read_buffer_capture_enable,
  output logic                           done,
  output logic                           capture,
  output logic                           addr_drive_oe_n,
  output logic [bus_xfer_pkg::ADDR_W-1:0] addr_out,
  output logic                           diag,
  output logic                           addr_latch,
  output logic                           memory_drive_permit,
  output logic                           same_page_store_flag,
  output logic                           read_n,
  output logic                           write_n
);
  import bus_xfer_pkg::*;

  bus_state_t state_q;
  logic [1:0] ack_s_q, cen_s_q;
  logic       ack_prev_q, cen_prev_q;
  logic       ack_rise, cen_rise;
  logic       write_q, miss_q, instr_q, burst_q, last_wr_valid_q;
  logic [1:0] items_q;
  logic [2:0] beat_q;
  logic [ADDR_W-1:PAGE_LSB] last_page_q;
  logic       near;

  // two-flop synchronisers; edges are taken from the second stage only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ack_s_q    <= SYNC_RESET;
      cen_s_q    <= SYNC_RESET;
      ack_prev_q <= 1'b0;
      cen_prev_q <= 1'b0;
    end else begin
      ack_s_q    <= {ack_s_q[0], ack_pin};
      cen_s_q    <= {cen_s_q[0], read_buffer_capture_enable};
      ack_prev_q <= ack_s_q[1];
      cen_prev_q <= cen_s_q[1];
    end
  end
  assign ack_rise = ack_s_q[1] && !ack_prev_q;
  assign cen_rise = cen_s_q[1] && !cen_prev_q;

  assign near = last_wr_valid_q && (req_addr[ADDR_W-1:PAGE_LSB] == last_page_q);

  // transaction sequencer
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      beat_q  <= 3'h0;
      items_q <= 2'h0;
      write_q <= 1'b0;
      miss_q  <= 1'b0;
      instr_q <= 1'b0;
      burst_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (req) begin
            state_q <= ST_ADDR;
            write_q <= req_write;
            miss_q  <= req_miss;
            instr_q <= req_instr;
            items_q <= req_items;
            beat_q  <= 3'h0;
            burst_q <= !req_write && req_miss && (req_instr || dblock_refill_en);
          end
        end
        ST_ADDR: begin
          state_q <= write_q ? ST_DATA : ST_TURN;
        end
        ST_TURN: begin
          state_q <= ST_DATA;
        end
        ST_DATA: begin
          if (ack_rise) begin
            if (write_q && (beat_q[1:0] != items_q)) begin
              beat_q <= beat_q + 3'h1;
            end else if (!write_q && burst_q && (beat_q != BEAT_LAST)) begin
              beat_q <= beat_q + 3'h1;
            end else begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // page tracker for same-page write flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      last_wr_valid_q      <= 1'b0;
      last_page_q          <= '0;
      same_page_store_flag <= 1'b0;
    end else if (state_q == ST_IDLE && req) begin
      if (req_write) begin
        same_page_store_flag <= near;
        last_wr_valid_q      <= 1'b1;
        last_page_q          <= req_addr[ADDR_W-1:PAGE_LSB];
      end else begin
        // a read breaks the back-to-back write sequence
        last_wr_valid_q      <= 1'b0;
        same_page_store_flag <= !req_write && req_miss && (req_instr || dblock_refill_en);
      end
    end else if (state_q == ST_DONE) begin
      same_page_store_flag <= 1'b0;
    end
  end

  // bus pins, all registered
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_latch          <= 1'b0;
      addr_out            <= '0;
      addr_drive_oe_n     <= 1'b1;
      memory_drive_permit <= 1'b0;
      read_n              <= 1'b1;
      write_n             <= 1'b1;
      diag                <= 1'b0;
    end else begin
      addr_latch <= (state_q == ST_IDLE) && req;
      if (state_q == ST_IDLE && req) begin
        addr_out        <= req_addr;
        addr_drive_oe_n <= 1'b0;
        diag            <= !req_write && req_miss;
      end else if (state_q == ST_ADDR) begin
        addr_drive_oe_n <= !write_q;
        diag            <= !write_q && instr_q;
      end else if (state_q == ST_DONE) begin
        addr_drive_oe_n <= 1'b1;
      end
      // permit only after our drivers went off a cycle earlier
      memory_drive_permit <= (state_q == ST_TURN || state_q == ST_DATA) && !write_q
                             && !(state_q == ST_DATA && ack_rise && (!burst_q || beat_q == BEAT_LAST));
      read_n  <= !((state_q == ST_TURN) || (state_q == ST_DATA && !write_q && !(ack_rise && (!burst_q || beat_q == BEAT_LAST))));
      write_n <= !((state_q == ST_ADDR && write_q) || (state_q == ST_DATA && write_q && !(ack_rise && beat_q[1:0] == items_q)));
    end
  end

  assign done    = (state_q == ST_DONE);
  assign capture = cen_rise && (state_q == ST_DATA) && !write_q;

  // assertions
  property p_no_both;
    @(posedge ref_clk) disable iff (!nrst) !(!read_n && !write_n);
  endproperty
  a_no_both: assert property (p_no_both) else $error("read and write strobes together");

  property p_ale_from_idle;
    @(posedge ref_clk) disable iff (!nrst) (state_q == ST_IDLE && req) |=> addr_latch ##1 !addr_latch;
  endproperty
  a_ale_from_idle: assert property (p_ale_from_idle) else $error("address strobe not one pulse");

  property p_permit_safe;
    @(posedge ref_clk) disable iff (!nrst) memory_drive_permit |-> addr_drive_oe_n && $past(addr_drive_oe_n);
  endproperty
  a_permit_safe: assert property (p_permit_safe) else $error("permit while bus driven");

  property p_burst_only_miss;
    @(posedge ref_clk) disable iff (!nrst)
      (state_q == ST_ADDR && !write_q && same_page_store_flag) |-> miss_q && (instr_q || dblock_refill_en);
  endproperty
  a_burst_only_miss: assert property (p_burst_only_miss) else $error("burst on non-miss read");

  property p_imiss_burst;
    @(posedge ref_clk) disable iff (!nrst) (state_q == ST_IDLE && req && !req_write && req_miss && req_instr) |=> same_page_store_flag;
  endproperty
  a_imiss_burst: assert property (p_imiss_burst) else $error("no burst on instruction miss");

  property p_near;
    @(posedge ref_clk) disable iff (!nrst) (state_q == ST_IDLE && req && req_write) |=> same_page_store_flag == $past(near);
  endproperty
  a_near: assert property (p_near) else $error("same page flag wrong");

  property p_diag_addr;
    @(posedge ref_clk) disable iff (!nrst) (state_q == ST_IDLE && req && !req_write) |=> diag == $past(req_miss);
  endproperty
  a_diag_addr: assert property (p_diag_addr) else $error("diag miss phase wrong");

  property p_diag_data;
    @(posedge ref_clk) disable iff (!nrst) (state_q == ST_ADDR && !write_q) |=> diag == $past(instr_q);
  endproperty
  a_diag_data: assert property (p_diag_data) else $error("diag source phase wrong");

  property p_read_strobe;
    @(posedge ref_clk) disable iff (!nrst) (state_q == ST_TURN) |=> !read_n;
  endproperty
  a_read_strobe: assert property (p_read_strobe) else $error("read strobe missing");

  property p_write_strobe;
    @(posedge ref_clk) disable iff (!nrst) (state_q == ST_ADDR && write_q) |=> !write_n;
  endproperty
  a_write_strobe: assert property (p_write_strobe) else $error("write strobe missing");

  property p_wr_end;
    @(posedge ref_clk) disable iff (!nrst)
      (state_q == ST_DATA && write_q && ack_rise && beat_q[1:0] == items_q) |=> state_q == ST_DONE ##1 state_q == ST_IDLE;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write did not end on ack");

  property p_rd_done;
    @(posedge ref_clk) disable iff (!nrst)
      (state_q == ST_DATA && !write_q && ack_rise && !burst_q) |=> done;
  endproperty
  a_rd_done: assert property (p_rd_done) else $error("read done missing");

  c_read:  cover property (@(posedge ref_clk) disable iff (!nrst) state_q == ST_TURN ##[1:50] done);
  c_write: cover property (@(posedge ref_clk) disable iff (!nrst) (state_q == ST_ADDR && write_q) ##[1:50] done);
  c_burst: cover property (@(posedge ref_clk) disable iff (!nrst) state_q == ST_DATA && burst_q && beat_q == BEAT_LAST);
  c_near:  cover property (@(posedge ref_clk) disable iff (!nrst) same_page_store_flag && !write_n);
endmodule
`default_nettype wire

// ==== rtl/bus_xfer_pkg.sv ====
/*
  constants and types for the bus transfer control block.
  assumes a single 250 MHz clock domain.
*/
package bus_xfer_pkg;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned PAGE_LSB     = 8;
  localparam int unsigned BURST_WORDS  = 4;
  localparam logic [2:0]  BEAT_LAST    = 3'h3;
  localparam logic [1:0]  SYNC_RESET   = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_TURN  = 3'b010,
    ST_DATA  = 3'b011,
    ST_DONE  = 3'b100
  } bus_state_t;
endpackage

// ==== testbench/bus_xfer_ctrl_tb.sv ====
/* self-checking bench for the bus transfer control block.
   assumes the memory partner model in its own file. */
`timescale 1ns/1ps
`default_nettype none
module bus_xfer_ctrl_tb;
  import bus_xfer_pkg::*;
  logic              ref_clk, nrst, req, req_write, req_miss, req_instr, dblock_refill_en;
  logic [1:0]        req_items;
  logic [ADDR_W-1:0] req_addr, addr_out, latched_addr;
  logic              done, capture, addr_drive_oe_n, diag, addr_latch, memory_drive_permit;
  logic              same_page_store_flag, read_n, write_n, ack_pin, read_buffer_capture_enable;
  logic              diag_a, diag_b, flag_a, seen_rd, seen_wr, seen_pm;
  logic              lat_nx = 1'h0;
  logic [3:0]        wait_cyc;
  int                beats, caps, lat_cnt, miscompares = 0, n_checks = 0, cycles = 0;

  bus_xfer_ctrl dut_u (.ref_clk, .nrst, .req, .req_write, .req_miss, .req_instr, .req_items,
    .req_addr, .dblock_refill_en, .ack_pin, .read_buffer_capture_enable, .done, .capture,
    .addr_drive_oe_n, .addr_out, .diag, .addr_latch, .memory_drive_permit,
    .same_page_store_flag, .read_n, .write_n);
  mem_partner_model partner_u (.ref_clk, .read_n, .write_n, .addr_latch, .memory_drive_permit,
    .addr_out, .wait_cyc, .ack_pin, .read_buffer_capture_enable, .latched_addr, .beats);

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // a hung handshake ends the run here rather than stalling the simulator
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  always @(negedge ref_clk) begin
    if (nrst) begin
      if (lat_nx) diag_b = diag;
      lat_nx = addr_latch;
      if (addr_latch) begin
        diag_a = diag;
        flag_a = same_page_store_flag;
        lat_cnt++;
      end
      if (capture) caps++;
      if (!read_n) seen_rd = 1'h1;
      if (!write_n) seen_wr = 1'h1;
      if (memory_drive_permit) seen_pm = 1'h1;
      check(!read_n && !write_n, 1'h0, "both strobes");
      check(memory_drive_permit && (!addr_drive_oe_n || !write_n), 1'h0, "permit");
    end
  end

  task automatic xfer(input logic w, m, i, input logic [1:0] it, input logic [31:0] a,
                      input logic ef, input int eb);
    int n0, k;
    n0 = beats;
    k = 0;
    caps = 0;
    lat_cnt = 0;
    seen_rd = 1'h0;
    seen_wr = 1'h0;
    seen_pm = 1'h0;
    {req_write, req_miss, req_instr, req_items, req_addr} = {w, m, i, it, a};
    req = 1'h1;
    while (done !== 1'h1 && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    req = 1'h0;
    check(k < 400, 1'h1, "no done");
    check(latched_addr, a, "latched address");
    check(lat_cnt, 1, "address strobes");
    check(seen_rd, !w, "read strobe");
    check(seen_wr, w, "write strobe");
    check(seen_pm, !w, "drive permit");
    check(flag_a, ef, "burst or near flag");
    check(beats - n0, eb, "items acked");
    if (!w) begin
      check(diag_a, m, "diag miss slot");
      check(diag_b, i, "diag ref slot");
      check(caps, eb, "captures before done");
    end
    @(negedge ref_clk);
  endtask

  task automatic t_instr_miss();
    dblock_refill_en = 1'h0;
    xfer(1'h0, 1'h1, 1'h1, 2'h0, 32'h0000_1000, 1'h1, 4);
  endtask

  task automatic t_data_miss();
    dblock_refill_en = 1'h0;
    xfer(1'h0, 1'h1, 1'h0, 2'h0, 32'h0000_2040, 1'h0, 1);
    dblock_refill_en = 1'h1;
    xfer(1'h0, 1'h1, 1'h0, 2'h0, 32'h0000_2080, 1'h1, 4);
  endtask

  task automatic t_uncached();
    xfer(1'h0, 1'h0, 1'h1, 2'h0, 32'h8000_0010, 1'h0, 1);
  endtask

  // slow partner; a read in between clears the page tracker
  task automatic t_writes();
    wait_cyc = 4'h6;
    xfer(1'h1, 1'h0, 1'h0, 2'h0, 32'h0000_3000, 1'h0, 1);
    xfer(1'h1, 1'h0, 1'h0, 2'h2, 32'h0000_30FC, 1'h1, 3);
    xfer(1'h1, 1'h0, 1'h0, 2'h0, 32'h0000_3100, 1'h0, 1);
    xfer(1'h0, 1'h0, 1'h0, 2'h0, 32'h0000_3104, 1'h0, 1);
    xfer(1'h1, 1'h0, 1'h0, 2'h0, 32'h0000_3108, 1'h0, 1);
    wait_cyc = 4'h0;
  endtask

  task automatic t_reset_mid();
    req_write = 1'h1;
    req = 1'h1;
    repeat (4) @(negedge ref_clk);
    nrst = 1'h0;
    req = 1'h0;
    #1;
    check({read_n, write_n, addr_drive_oe_n, addr_latch}, 4'hE, "reset outputs");
    @(negedge ref_clk);
    nrst = 1'h1;
    repeat (20) @(negedge ref_clk);
  endtask

  initial begin
    {nrst, req, req_write, req_miss, req_instr, dblock_refill_en} = 6'h0;
    req_items = 2'h0;
    req_addr = '0;
    wait_cyc = 4'h0;
    repeat (4) @(negedge ref_clk);
    nrst = 1'h1;
    @(negedge ref_clk);
    t_instr_miss();
    t_data_miss();
    t_uncached();
    t_writes();
    t_reset_mid();
    t_instr_miss();
    final_report();
  end
endmodule
`default_nettype wire

// ==== testbench/mem_partner_model.sv ====
/* behavioural memory system: latches the address and answers each item
   with a capture enable (reads only) then one ack pulse.
   assumes active-low strobes and one counted ack edge per item. */
`timescale 1ns/1ps
`default_nettype none
module mem_partner_model (
  input  wire logic        ref_clk,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        addr_latch,
  input  wire logic        memory_drive_permit,
  input  wire logic [31:0] addr_out,
  input  wire logic [3:0]  wait_cyc,
  output logic             ack_pin,
  output logic             read_buffer_capture_enable,
  output logic [31:0]      latched_addr,
  output int               beats
);
  initial begin
    ack_pin = 1'h0;
    read_buffer_capture_enable = 1'h0;
    beats = 0;
  end
  always @(posedge ref_clk) if (addr_latch) latched_addr <= addr_out;
  // levels held two cycles so the block's synchroniser sees every edge
  always begin
    @(posedge ref_clk);
    if (!read_n || !write_n) begin
      repeat (wait_cyc) @(posedge ref_clk);
      for (int k = 0; k < 8 && !read_n && !memory_drive_permit; k++) @(posedge ref_clk);
      read_buffer_capture_enable <= !read_n;
      repeat (2) @(posedge ref_clk);
      read_buffer_capture_enable <= 1'h0;
      ack_pin <= 1'h1;
      beats <= beats + 1;
      repeat (2) @(posedge ref_clk);
      ack_pin <= 1'h0;
      repeat (5) @(posedge ref_clk);
    end
  end
endmodule
`default_nettype wire
